/* File: ptl_pkg.sv */
// Shared constants, types and register map of the host-to-local bus bridge
package ptl_pkg;
	localparam int NWIN = 5;
	// Host bus command codes
	localparam logic [3:0] CMD_IO_RD       = 4'h2;
	localparam logic [3:0] CMD_IO_WR       = 4'h3;
	localparam logic [3:0] CMD_MEM_RD      = 4'h6;
	localparam logic [3:0] CMD_MEM_WR      = 4'h7;
	localparam logic [3:0] CMD_CFG_RD      = 4'ha;
	localparam logic [3:0] CMD_CFG_WR      = 4'hb;
	localparam logic [3:0] CMD_MEM_RD_MUL  = 4'hc;
	localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
	localparam logic [3:0] CMD_MEM_WR_INV  = 4'hf;
	// Register port offsets
	localparam logic [7:0] REG_DESC_BASE = 8'h00;
	localparam logic [7:0] REG_MASK_BASE = 8'h20;
	localparam logic [7:0] REG_BAR_BASE  = 8'h40;
	localparam logic [7:0] REG_CTRL      = 8'h60;
	localparam logic [7:0] REG_STAT      = 8'h64;
	// Window descriptor fields
	localparam int DESC_WID_LSB  = 0;
	localparam int DESC_RDY_EN   = 2;
	localparam int DESC_BURST_TERMINATE_N_EN = 3;
	localparam int DESC_WAIT_LSB = 4;
	localparam int DESC_PREF     = 8;
	localparam int DESC_IO       = 9;
	localparam int DESC_EN       = 10;
	localparam int DESC_W        = 11;
	localparam logic [DESC_W-1:0] DESC_RESET = 11'h002;
	localparam logic [31:0]       MASK_RESET = 32'hffff_f000;
	localparam logic [31:0]       BAR_RESET  = 32'h0000_0000;
	// Control fields
	localparam int CTRL_PREF_EN   = 0;
	localparam int CTRL_BAR5_PREF = 1;
	localparam int CTRL_W         = 2;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
	// Configuration space
	localparam logic [5:0] CFG_BAR0_DW  = 6'h04;
	localparam logic [5:0] CFG_BAR5_DW  = 6'h09;
	localparam int         BAR_ADDR_LSB = 4;
	localparam logic [31:0] IO_DECODE_MASK = 32'hffff_fffc;
	// Local bus widths and lanes
	localparam logic [1:0] WID_8  = 2'h0;
	localparam logic [1:0] WID_16 = 2'h1;
	localparam logic [1:0] WID_32 = 2'h2;
	localparam logic [3:0] LANES_LO  = 4'h3;
	localparam logic [3:0] LANES_HI  = 4'hc;
	localparam logic [3:0] LANES_ALL = 4'hf;
	localparam logic [1:0] LANE_HI_HALF = 2'h2;
	// Synchroniser reset: mode low, ready and terminate idle high
	localparam logic [2:0] SYNC_RESET = 3'h3;

	typedef logic [1:0] ptl_width_t;

	typedef enum logic [3:0] {
		LS_IDLE  = 4'b0001,
		LS_ADDR  = 4'b0010,
		LS_DATA  = 4'b0100,
		LS_RECOV = 4'b1000
	} ptl_lstate_t;

	typedef enum logic [4:0] {
		PS_IDLE  = 5'b00001,
		PS_CLAIM = 5'b00010,
		PS_LOCAL = 5'b00100,
		PS_DONE  = 5'b01000,
		PS_TURN  = 5'b10000
	} ptl_pstate_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic cfg;
		logic io;
	} ptl_cmd_t;

	typedef struct packed {
		logic [25:0] word;
		logic [3:0]  lanes;
		logic [31:0] wdata;
		logic        write;
		ptl_width_t  width;
		logic [3:0]  waits;
		logic        rdy_en;
		logic        burst_terminate_n_en;
	} ptl_req_t;

	typedef struct packed {
		logic        ads_n;
		logic        ale;
		logic        last_transfer_n_n;
		logic        wait_n;
		logic        dir;
		logic [3:0]  lbe_n;
		logic        ble_n;
		logic        bhe_n;
		logic [25:0] word;
		logic [1:0]  lowa;
		logic [31:0] lad;
		logic        lad_oe;
	} ptl_lout_t;

	localparam ptl_lout_t LOUT_RESET = '{ads_n: 1'b1, ale: 1'b0, last_transfer_n_n: 1'b1, wait_n: 1'b1,
		dir: 1'b0, lbe_n: 4'hf, ble_n: 1'b1, bhe_n: 1'b1, word: 26'h0, lowa: 2'h0,
		lad: 32'h0, lad_oe: 1'b0};

	function automatic ptl_cmd_t ptl_decode_cmd(input logic [3:0] c);
		ptl_cmd_t r;
		r = '{valid: 1'b1, write: 1'b0, cfg: 1'b0, io: 1'b0};
		case (c)
			CMD_IO_RD: r.io = 1'b1;
			CMD_IO_WR: begin
				r.io = 1'b1;
				r.write = 1'b1;
			end
			CMD_MEM_RD, CMD_MEM_RD_MUL, CMD_MEM_RD_LINE: r.write = 1'b0;
			CMD_MEM_WR, CMD_MEM_WR_INV: r.write = 1'b1;
			CMD_CFG_RD: r.cfg = 1'b1;
			CMD_CFG_WR: begin
				r.cfg = 1'b1;
				r.write = 1'b1;
			end
			default: r.valid = 1'b0;
		endcase
		return r;
	endfunction
endpackage

/* File: ptl_beat_plan.sv */
// Picks the lanes, lane address and last flag of the next local beat
`timescale 1ns/1ns
`default_nettype none
module ptl_beat_plan (
	// Lanes still to move and local width
	input  wire logic [3:0]         rem_i,
	input  wire ptl_pkg::ptl_width_t width_i,
	// Next beat
	output logic      [3:0]         beat_o,
	output logic      [1:0]         lane_o,
	output logic                    last_o
);
	import ptl_pkg::*;

	always_comb begin
		beat_o = rem_i;
		lane_o = 2'h0;
		if (width_i == WID_8) begin
			beat_o = 4'h0;
			for (int i = 3; i >= 0; i--) begin
				if (rem_i[i]) begin
					beat_o = 4'h1 << i;
					lane_o = 2'(i);
				end
			end
		end else if (width_i == WID_16) begin
			if ((rem_i & LANES_LO) != 4'h0) begin
				beat_o = rem_i & LANES_LO;
			end else begin
				beat_o = rem_i & LANES_HI;
				lane_o = LANE_HI_HALF;
			end
		end
		last_o = (rem_i & ~beat_o) == 4'h0;
	end
endmodule
`default_nettype wire

/* File: ptl_bridge.sv */
// Host bus target bridging onto a programmable local bus master
// What this block does
// [R1] Accept I/O, memory, configuration reads and writes
// [R2] Alias extended memory commands to plain memory
// [R3] Honour byte, word and longword access sizes
// [R4] I/O decode ignores two lowest address bits
// [R5] Target ready inserts host wait states
// [R6] Host byte n sits on lane n
// [R7] Base window prefetch bit from local settings
// [R8] Own prefetching off until enabled locally
// [R9] Split longword into bytes for 8-bit windows
// [R10] Split longword into halfwords for 16-bit windows
// [R11] 8-bit writes stop at first lane gap
// [R12] Host splits nonadjacent 8-bit accesses itself
// [R13] Unlimited bursts, width from hit window; the bridge disconnects after one data phase instead
// [R14] Access runs strobe through last-transfer end
// [R15] Address state drives strobe, latch, address
// [R16] Idle, address, data/wait, recovery per local clock
// [R17] Last-transfer low through final data state
// [R18] Recovery state only in multiplexed mode
// [R19] Slave ready or internal counter stretches data
// [R20] Local signals act on local clock rise
// [R21] Non-multiplexed: address lines, data-only shared bus
// [R22] Narrow data low lanes, writes replicated
// [R23] Multiplexed address phase, low bits from selects
// [R24] Mode pin picks multiplexed or dedicated bus
// [R25] Direction valid in address phase
// [R26] Local signals cross via two-flop synchronisers
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module ptl_bridge (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_b_i,
	// Host bus
	input  wire logic        host_frame_n_i,
	input  wire logic        host_irdy_n_i,
	input  wire logic        host_idsel_i,
	input  wire logic [31:0] host_ad_i,
	input  wire logic [3:0]  host_cbe_n_i,
	output logic      [31:0] host_ad_o,
	output logic             host_ad_oe_o,
	output logic             host_trdy_n_o,
	output logic             host_devsel_n_o,
	output logic             host_stop_n_o,
	output logic             host_ctl_oe_o,
	// Register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// Local bus inputs
	input  wire logic        local_clock_i,
	input  wire logic        bus_mode_i,
	input  wire logic        slave_ready_in_n_i,
	input  wire logic        burst_terminate_n_i,
	input  wire logic [31:0] local_shared_bus_i,
	// Local bus outputs
	output logic      [31:0] local_shared_bus_o,
	output logic             local_shared_bus_oe_o,
	output logic      [27:2] local_address_lines_o,
	output logic      [1:0]  local_low_addr_o,
	output logic      [3:0]  local_byte_selects_n_o,
	output logic             low_byte_select_n_o,
	output logic             high_byte_select_n_o,
	output logic             addr_strobe_n_o,
	output logic             addr_latch_o,
	output logic             last_transfer_n_o,
	output logic             internal_wait_out_n_o,
	output logic             transfer_direction_o
);
	import ptl_pkg::*;

	logic [2:0]        local_clock_sync_q;
	logic [2:0]        ctl_s1_q;
	logic [2:0]        ctl_s2_q;
	logic [31:0]       lad_s1_q;
	logic [31:0]       lad_s2_q;
	logic              local_clock_rise;
	logic              mode_q;
	logic              rdy_n_q;
	logic              burst_terminate_n_n_q;
	logic [DESC_W-1:0] desc_q [NWIN];
	logic [31:0]       mask_q [NWIN];
	logic [31:0]       base_q [NWIN];
	logic [CTRL_W-1:0] ctrl_q;
	logic [31:0]       reg_rdata_q;
	logic [3:0]        dwin;
	logic [3:0]        mwin;
	logic [3:0]        bwin;
	ptl_pstate_t       ps_q;
	ptl_cmd_t          cmd_q;
	ptl_cmd_t          cmd_now;
	logic              frame_n_prev_q;
	logic              hit_now;
	logic [2:0]        win_now;
	logic [2:0]        win_q;
	logic [31:0]       haddr_q;
	logic [31:0]       host_rdata_q;
	logic [31:0]       cfg_rdata;
	logic [DESC_W-1:0] wdesc;
	logic [3:0]        lanes_now;
	ptl_req_t          lreq_q;
	logic              req_q;
	ptl_lstate_t       ls_q;
	logic [3:0]        rem_q;
	logic [3:0]        wcnt_q;
	logic [31:0]       rd_acc_q;
	logic              done_q;
	logic [3:0]        beat;
	logic [1:0]        lane;
	logic              beat_last;
	logic              beat_done;
	ptl_lout_t         lout_q;

	function automatic logic [3:0] reg_win(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] off;
		off = a - b;
		return {(a >= b) && (off < 8'(4 * NWIN)) && (off[1:0] == 2'h0), off[4:2]};
	endfunction

	function automatic logic win_match(input logic [31:0] a, input logic [31:0] b,
			input logic [31:0] m, input logic [DESC_W-1:0] d, input logic io_cmd);
		logic [31:0] cm;
		cm = io_cmd ? (m & IO_DECODE_MASK) : m;
		return d[DESC_EN] && (d[DESC_IO] == io_cmd) && ((a & cm) == (b & cm));
	endfunction

	// Lanes up to the first gap; later lanes would get a wrong byte address
	function automatic logic [3:0] first_run(input logic [3:0] l);
		logic [3:0] r;
		logic       seen;
		logic       gap;
		r = 4'h0;
		seen = 1'b0;
		gap = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (l[i] && !gap) begin
				r[i] = 1'b1;
				seen = 1'b1;
			end else if (seen && !l[i]) begin
				gap = 1'b1;
			end
		end
		return r;
	endfunction

	// Host lane i comes from local lane i, its half, or the low byte
	function automatic logic [7:0] pick_byte(input logic [31:0] d, input ptl_width_t w, input int i);
		if (w == WID_8)
			return d[7:0];
		else if (w == WID_16)
			return d[(i % 2) * 8 +: 8];
		return d[i * 8 +: 8];
	endfunction

	function automatic logic [31:0] replicate(input logic [31:0] d, input ptl_width_t w,
			input logic [1:0] ln);
		if (w == WID_8)
			return {4{d[ln * 8 +: 8]}};
		else if (w == WID_16)
			return {2{d[ln * 8 +: 16]}};
		return d;
	endfunction

	// Local clock, strap and handshake inputs arrive from outside this clock
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			local_clock_sync_q <= 3'h0;
			ctl_s1_q <= SYNC_RESET;
			ctl_s2_q <= SYNC_RESET;
			lad_s1_q <= 32'h0;
			lad_s2_q <= 32'h0;
		end else begin
			local_clock_sync_q <= {local_clock_sync_q[1:0], local_clock_i}; // R26
			ctl_s1_q <= {bus_mode_i, slave_ready_in_n_i, burst_terminate_n_i};
			ctl_s2_q <= ctl_s1_q; // R26
			lad_s1_q <= local_shared_bus_i;
			lad_s2_q <= lad_s1_q;
		end
	end
	assign local_clock_rise = local_clock_sync_q[1] & ~local_clock_sync_q[2]; // R20
	assign mode_q = ctl_s2_q[2]; // R24
	assign rdy_n_q = ctl_s2_q[1];
	assign burst_terminate_n_n_q = ctl_s2_q[0];

	assign dwin = reg_win(reg_addr_i, REG_DESC_BASE);
	assign mwin = reg_win(reg_addr_i, REG_MASK_BASE);
	assign bwin = reg_win(reg_addr_i, REG_BAR_BASE);

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			for (int k = 0; k < NWIN; k++) begin
				desc_q[k] <= DESC_RESET;
				mask_q[k] <= MASK_RESET;
			end
			ctrl_q <= CTRL_RESET; // R8
		end else if (reg_wr_i) begin
			if (dwin[3])
				desc_q[dwin[2:0]] <= reg_wdata_i[DESC_W-1:0];
			else if (mwin[3])
				mask_q[mwin[2:0]] <= reg_wdata_i;
			else if (reg_addr_i == REG_CTRL)
				ctrl_q <= reg_wdata_i[CTRL_W-1:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			reg_rdata_q <= 32'h0;
		end else begin
			reg_rdata_q <= 32'h0;
			if (reg_rd_i) begin
				if (dwin[3])
					reg_rdata_q <= 32'(desc_q[dwin[2:0]]);
				else if (mwin[3])
					reg_rdata_q <= mask_q[mwin[2:0]];
				else if (bwin[3])
					reg_rdata_q <= base_q[bwin[2:0]];
				else if (reg_addr_i == REG_CTRL)
					reg_rdata_q <= 32'(ctrl_q);
				else if (reg_addr_i == REG_STAT)
					reg_rdata_q <= 32'({mode_q, ls_q, ps_q});
			end
		end
	end
	assign reg_rdata_o = reg_rdata_q;

	// Address phase decode; lowest matching window wins
	always_comb begin
		cmd_now = ptl_decode_cmd(host_cbe_n_i); // R1 R2
		hit_now = 1'b0;
		win_now = 3'h0;
		for (int k = NWIN - 1; k >= 0; k--) begin
			if (win_match(host_ad_i, base_q[k], mask_q[k], desc_q[k], cmd_now.io)) begin // R4
				hit_now = 1'b1;
				win_now = 3'(k);
			end
		end
		if (cmd_now.cfg)
			hit_now = host_idsel_i;
		if (!cmd_now.valid)
			hit_now = 1'b0;
	end

	always_comb begin
		cfg_rdata = 32'h0;
		for (int k = 0; k < NWIN; k++) begin
			if (haddr_q[7:2] == CFG_BAR0_DW + 6'(k))
				cfg_rdata = {base_q[k][31:BAR_ADDR_LSB], desc_q[k][DESC_PREF], 2'h0,
					desc_q[k][DESC_IO]}; // R7
		end
		if (haddr_q[7:2] == CFG_BAR5_DW)
			cfg_rdata = {28'h0, ctrl_q[CTRL_BAR5_PREF], 3'h0}; // R7
	end

	always_comb begin
		wdesc = desc_q[win_q];
		lanes_now = ~host_cbe_n_i; // R3 R6
		if (cmd_q.write && wdesc[DESC_WID_LSB +: 2] == WID_8)
			lanes_now = first_run(lanes_now); // R11
		else if (!cmd_q.write && !cmd_q.io && ctrl_q[CTRL_PREF_EN]
				&& wdesc[DESC_WID_LSB +: 2] == WID_32)
			lanes_now = LANES_ALL; // R8
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			for (int k = 0; k < NWIN; k++)
				base_q[k] <= BAR_RESET;
		end else if (ps_q == PS_CLAIM && !host_irdy_n_i && cmd_q.cfg && cmd_q.write) begin
			for (int k = 0; k < NWIN; k++) begin
				if (haddr_q[7:2] == CFG_BAR0_DW + 6'(k))
					base_q[k] <= host_ad_i & mask_q[k];
			end
		end
	end

	// Host target: one data phase per transaction, then disconnect
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			ps_q <= PS_IDLE;
			frame_n_prev_q <= 1'b1;
			cmd_q <= '{valid: 1'b0, write: 1'b0, cfg: 1'b0, io: 1'b0};
			win_q <= 3'h0;
			haddr_q <= 32'h0;
			host_rdata_q <= 32'h0;
			req_q <= 1'b0;
			lreq_q <= '0;
		end else begin
			frame_n_prev_q <= host_frame_n_i;
			case (ps_q)
				PS_IDLE: if (!host_frame_n_i && frame_n_prev_q && hit_now) begin
					cmd_q <= cmd_now;
					haddr_q <= host_ad_i;
					win_q <= win_now;
					ps_q <= PS_CLAIM;
				end
				PS_CLAIM: if (!host_irdy_n_i) begin
					if (cmd_q.cfg) begin
						host_rdata_q <= cfg_rdata;
						ps_q <= PS_DONE;
					end else begin
						lreq_q.word <= 26'((haddr_q & ~mask_q[win_q]) >> 2); // R13
						lreq_q.lanes <= lanes_now;
						lreq_q.wdata <= host_ad_i;
						lreq_q.write <= cmd_q.write;
						lreq_q.width <= wdesc[DESC_WID_LSB +: 2]; // R13
						lreq_q.waits <= wdesc[DESC_WAIT_LSB +: 4];
						lreq_q.rdy_en <= wdesc[DESC_RDY_EN];
						lreq_q.burst_terminate_n_en <= wdesc[DESC_BURST_TERMINATE_N_EN];
						req_q <= 1'b1;
						ps_q <= PS_LOCAL;
					end
				end
				PS_LOCAL: if (done_q) begin
					host_rdata_q <= rd_acc_q;
					req_q <= 1'b0;
					ps_q <= PS_DONE;
				end
				PS_DONE: ps_q <= PS_TURN;
				PS_TURN: if (host_frame_n_i)
					ps_q <= PS_IDLE;
				default: ps_q <= PS_IDLE;
			endcase
		end
	end

	// Wait states held by target ready until the data is in hand
	assign host_trdy_n_o = ps_q != PS_DONE; // R5
	assign host_stop_n_o = !(ps_q == PS_DONE || ps_q == PS_TURN);
	assign host_devsel_n_o = ps_q == PS_IDLE;
	assign host_ctl_oe_o = ps_q != PS_IDLE;
	assign host_ad_o = host_rdata_q;
	assign host_ad_oe_o = ps_q == PS_DONE && !cmd_q.write;

	ptl_beat_plan u_plan (
		.rem_i   (rem_q),
		.width_i (lreq_q.width),
		.beat_o  (beat),
		.lane_o  (lane),
		.last_o  (beat_last)
	);

	// Terminate overrides ready; neither is looked at while the counter runs
	assign beat_done = (lreq_q.burst_terminate_n_en && !burst_terminate_n_n_q) || !lreq_q.rdy_en || !rdy_n_q; // R19

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			ls_q <= LS_IDLE;
			rem_q <= 4'h0;
			wcnt_q <= 4'h0;
			rd_acc_q <= 32'h0;
			done_q <= 1'b0;
		end else begin
			if (!req_q)
				done_q <= 1'b0;
			if (local_clock_rise) begin // R20
				case (ls_q)
					LS_IDLE: if (req_q && !done_q) begin
						rem_q <= lreq_q.lanes;
						rd_acc_q <= 32'h0;
						ls_q <= LS_ADDR; // R14 R16
					end
					LS_ADDR: begin
						wcnt_q <= lreq_q.waits;
						ls_q <= LS_DATA;
					end
					LS_DATA: if (wcnt_q != 4'h0) begin
						wcnt_q <= wcnt_q - 4'h1; // R19
					end else if (beat_done) begin
						for (int i = 0; i < 4; i++) begin
							if (beat[i] && !lreq_q.write)
								rd_acc_q[i * 8 +: 8] <= pick_byte(lad_s2_q, lreq_q.width, i); // R22
						end
						rem_q <= rem_q & ~beat; // R9 R10
						wcnt_q <= lreq_q.waits;
						if (beat_last) begin
							done_q <= 1'b1;
							ls_q <= mode_q ? LS_RECOV : LS_IDLE; // R18
						end
					end
					LS_RECOV: ls_q <= LS_IDLE;
					default: ls_q <= LS_IDLE;
				endcase
			end
		end
	end

	// Pins follow the state one clock later, all together
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			lout_q <= LOUT_RESET;
		end else begin
			lout_q.ads_n <= ls_q != LS_ADDR; // R15
			lout_q.ale <= ls_q == LS_ADDR; // R15
			lout_q.last_transfer_n_n <= !(ls_q == LS_DATA && beat_last); // R17
			lout_q.wait_n <= !(ls_q == LS_DATA && wcnt_q != 4'h0); // R19
			lout_q.dir <= lreq_q.write; // R25
			lout_q.word <= lreq_q.word; // R21
			lout_q.lowa <= lane; // R9
			lout_q.lbe_n <= ~beat;
			lout_q.ble_n <= !(beat[0] | beat[2]); // R10
			lout_q.bhe_n <= !(beat[1] | beat[3]); // R10
			lout_q.lad_oe <= 1'b0;
			if (ls_q == LS_ADDR && mode_q) begin
				lout_q.lad <= {4'h0, lreq_q.word, ~beat[1:0]}; // R23
				lout_q.lad_oe <= 1'b1;
			end else if (ls_q == LS_DATA && lreq_q.write) begin
				lout_q.lad <= replicate(lreq_q.wdata, lreq_q.width, lane); // R22
				lout_q.lad_oe <= 1'b1;
			end
		end
	end

	assign addr_strobe_n_o = lout_q.ads_n;
	assign addr_latch_o = lout_q.ale;
	assign last_transfer_n_o = lout_q.last_transfer_n_n;
	assign internal_wait_out_n_o = lout_q.wait_n;
	assign transfer_direction_o = lout_q.dir;
	assign local_address_lines_o = lout_q.word;
	assign local_low_addr_o = lout_q.lowa;
	assign local_byte_selects_n_o = lout_q.lbe_n;
	assign low_byte_select_n_o = lout_q.ble_n;
	assign high_byte_select_n_o = lout_q.bhe_n;
	assign local_shared_bus_o = lout_q.lad;
	assign local_shared_bus_oe_o = lout_q.lad_oe;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	a_cmd_accept: assert property ((host_cbe_n_i == CMD_IO_WR) |-> cmd_now.valid && cmd_now.io // R1
		&& cmd_now.write) else $error("I/O write not accepted");
	a_cmd_alias: assert property ((host_cbe_n_i == CMD_MEM_WR_INV) |-> cmd_now.valid // R2
		&& cmd_now.write && !cmd_now.io && !cmd_now.cfg) else $error("Alias not plain write");
	a_io_lowbits: assert property (win_match(host_ad_i, base_q[0], mask_q[0], desc_q[0], 1'b1) // R4
		== win_match(host_ad_i ^ 32'h3, base_q[0], mask_q[0], desc_q[0], 1'b1))
		else $error("I/O decode used low bits");
	a_trdy_claim: assert property (!host_trdy_n_o |-> !host_devsel_n_o && !host_stop_n_o) // R5
		else $error("Ready without claim");
	a_gap_stop: assert property (ps_q == PS_CLAIM && !host_irdy_n_i && !cmd_q.cfg // R11
		&& cmd_q.write && wdesc[DESC_WID_LSB +: 2] == WID_8 && host_cbe_n_i == 4'ha
		|=> lreq_q.lanes == 4'h1) else $error("Write past lane gap");
	a_state_hold: assert property (!local_clock_rise |=> $stable(ls_q)) // R16
		else $error("Local state moved off edge");
	a_addr_strobe: assert property (ls_q == LS_ADDR |=> !addr_strobe_n_o && addr_latch_o) // R15
		else $error("Address state without strobe");
	a_last_flag: assert property (ls_q == LS_DATA && beat_last |=> !last_transfer_n_o) // R17
		else $error("Last transfer not flagged");
	a_recov_mux: assert property (local_clock_rise && ls_q == LS_DATA && wcnt_q == 4'h0 && beat_done // R18
		&& beat_last |=> (ls_q == LS_RECOV) == mode_q) else $error("Recovery mode mismatch");
	a_wait_hold: assert property (local_clock_rise && ls_q == LS_DATA && wcnt_q != 4'h0 // R19
		|=> ls_q == LS_DATA ##0 !internal_wait_out_n_o) else $error("Wait state skipped");
	a_dir_valid: assert property (!addr_strobe_n_o |-> transfer_direction_o == lreq_q.write) // R25
		else $error("Direction wrong in address phase");
	a_nomux_quiet: assert property (ls_q == LS_ADDR && !mode_q |=> !local_shared_bus_oe_o) // R21
		else $error("Shared bus driven with address");
	a_mux_addr: assert property (ls_q == LS_ADDR && mode_q |=> local_shared_bus_oe_o // R23
		&& local_shared_bus_o[1:0] == local_byte_selects_n_o[1:0]) else $error("Mux address bad");
	a_byte_repl: assert property (ls_q == LS_DATA && lreq_q.write && lreq_q.width == WID_8 // R22
		|=> local_shared_bus_o[31:24] == local_shared_bus_o[7:0]) else $error("No replication");
	a_done_clear: assert property (done_q && !req_q |=> !done_q) // R26
		else $error("Done not withdrawn");
endmodule
`default_nettype wire

/* File: ptl_local_slave.sv */
// Local bus slave model: word memory with a programmable ready delay
`timescale 1ns/1ns
`default_nettype none
module ptl_local_slave (
	// Clock, mode and ready delay
	input  wire logic        local_clock_i,
	input  wire logic        bus_mode_i,
	input  wire logic [3:0]  dly_i,
	// Bus from the master
	input  wire logic [31:0] lad_i,
	input  wire logic        lad_oe_i,
	input  wire logic [27:2] word_i,
	input  wire logic [1:0]  lowa_i,
	input  wire logic [3:0]  lbe_n_i,
	input  wire logic        ads_n_i,
	input  wire logic        dir_i,
	// Answers
	output logic      [31:0] lad_o,
	output logic             ready_n_o
);
	// Declaration values only, so the clocked process stays the one writer
	logic [31:0] mem [16] = '{default: 32'h0};
	logic [3:0]  wa = 4'h0;
	logic [3:0]  cnt = 4'h0;
	logic [31:0] rd;
	// Narrow beats answer on the low lanes
	assign rd = mem[wa] >> {lowa_i, 3'h0};
	// Outside a read the bus shows inverted data, never a stale match
	assign lad_o = (!dir_i && ads_n_i) ? rd : ~rd;
	always @(posedge local_clock_i) begin
		if (!ads_n_i) begin
			wa <= bus_mode_i ? lad_i[5:2] : word_i[5:2];
			cnt <= 4'h0;
		end else if (cnt != 4'hf)
			cnt <= cnt + 4'h1;
		ready_n_o <= ads_n_i ? (cnt < dly_i) : 1'b1;
		if (ads_n_i && lad_oe_i && dir_i)
			for (int j = 0; j < 4; j++)
				if (!lbe_n_i[j])
					mem[wa][8*j+:8] <= lad_i[8*j+:8];
	end
endmodule
`default_nettype wire

/* File: test_ptl_bridge.sv */
// Self-checking bench for the host-to-local bus bridge
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("mismatch %0t got %h want %h", $time, a, b); end end
module test_ptl_bridge;
	import ptl_pkg::*;
	logic        clk = 0, local_clock = 0, rst_b = 0, frame_n = 1, irdy_n = 1, idsel = 0;
	logic        mode = 0, rwr = 0, rrd = 0, rp = 0, had_oe, trdy_n, loe, ads, dir, rdy_n;
	logic        devsel_n, stop_n, ctl_oe;
	logic [3:0]  cbe_n = 4'hf, dly = 4'h0, lbe;
	logic [7:0]  raddr = 8'h0;
	logic [31:0] ad = 32'h0, rwd = 32'h0, hado, rdata, lo, li, a, x, y, e, wq;
	logic [27:2] law;
	logic [1:0]  lowa;
	logic [31:0] hq[$], rq[$];
	logic [10:0] dsc[4] = '{11'h506, 11'h421, 11'h414, 11'h606};
	logic [3:0]  rc[4] = '{CMD_MEM_RD, CMD_MEM_RD_MUL, CMD_MEM_RD_LINE, CMD_IO_RD};
	int          n_mismatch = 0, checks = 0, seed = 42, i, m;
	always #25 clk = ~clk;
	initial begin
		#7;
		forever #200 local_clock = ~local_clock;
	end
	ptl_bridge DUT (.clock_i(clk), .rst_b_i(rst_b), .host_frame_n_i(frame_n),
		.host_irdy_n_i(irdy_n), .host_idsel_i(idsel), .host_ad_i(ad), .host_cbe_n_i(cbe_n),
		.host_ad_o(hado), .host_ad_oe_o(had_oe), .host_trdy_n_o(trdy_n),
		.host_devsel_n_o(devsel_n), .host_stop_n_o(stop_n), .host_ctl_oe_o(ctl_oe),
		.reg_addr_i(raddr), .reg_wdata_i(rwd),
		.reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdata), .local_clock_i(local_clock),
		.bus_mode_i(mode), .slave_ready_in_n_i(rdy_n), .burst_terminate_n_i(1'b1),
		.local_shared_bus_i(li), .local_shared_bus_o(lo), .local_shared_bus_oe_o(loe),
		.local_address_lines_o(law), .local_low_addr_o(lowa), .local_byte_selects_n_o(lbe),
		.low_byte_select_n_o(), .high_byte_select_n_o(), .addr_strobe_n_o(ads),
		.addr_latch_o(), .last_transfer_n_o(), .internal_wait_out_n_o(),
		.transfer_direction_o(dir));
	ptl_local_slave slave (.local_clock_i(local_clock), .bus_mode_i(mode), .dly_i(dly), .lad_i(lo),
		.lad_oe_i(loe), .word_i(law), .lowa_i(lowa), .lbe_n_i(lbe), .ads_n_i(ads),
		.dir_i(dir), .lad_o(li), .ready_n_o(rdy_n));
	task automatic end_of_test;
		// Expected answers never delivered count against the run
		n_mismatch += hq.size() + rq.size();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Register access; a read carries its expected value in d
	task automatic rw(input logic [7:0] ra, input logic [31:0] d, input logic wr);
		raddr <= ra;
		rwd <= d;
		rwr <= wr;
		rrd <= !wr;
		if (!wr)
			rq.push_back(d);
		@(posedge clk);
		rwr <= 1'b0;
		rrd <= 1'b0;
		@(posedge clk);
	endtask
	// One host transaction; read commands have an even code
	task automatic hx(input logic [3:0] c, input logic [31:0] ha, input logic [3:0] be,
		input logic [31:0] d);
		int n;
		n = 0;
		if (!c[0])
			hq.push_back(d);
		frame_n <= 1'b0;
		ad <= ha;
		cbe_n <= c;
		idsel <= (c[3:1] == 3'h5);
		@(posedge clk);
		frame_n <= 1'b1;
		irdy_n <= 1'b0;
		cbe_n <= be;
		ad <= d;
		idsel <= 1'b0;
		do @(posedge clk); while (trdy_n !== 1'b0 && n++ < 4000);
		if (trdy_n !== 1'b0)
			n_mismatch++;
		irdy_n <= 1'b1;
		ad <= $random(seed);
		repeat (3) @(posedge clk);
	endtask
	always @(posedge clk) begin
		// Pop once: the macro names its operands twice
		if (rp) begin
			wq = rq.pop_front();
			`CHK(rdata, wq)
		end
		rp <= rrd;
		if (trdy_n === 1'b0)
			`CHK({ctl_oe, devsel_n, stop_n}, 3'h4)
		if (trdy_n === 1'b0 && had_oe === 1'b1) begin
			wq = hq.pop_front();
			`CHK(hado, wq)
		end
	end
	initial begin
		#3_000_000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rw(REG_DESC_BASE, {21'h0, DESC_RESET}, 1'b0);
		rw(REG_MASK_BASE, MASK_RESET, 1'b0);
		rw(REG_CTRL, 32'h0, 1'b0);
		rw(8'h80, 32'h0, 1'b0);
		for (i = 0; i < 4; i++) begin
			a = {16'h8000, 4'(i), 12'h0};
			rw(REG_DESC_BASE + 8'(4*i), {21'h0, dsc[i]}, 1'b1);
			rw(REG_DESC_BASE + 8'(4*i), {21'h0, dsc[i]}, 1'b0);
			hx(CMD_CFG_WR, {24'h0, 6'(CFG_BAR0_DW + i), 2'h0}, 4'h0, a);
			hx(CMD_CFG_RD, {24'h0, 6'(CFG_BAR0_DW + i), 2'h0}, 4'h0,
				{a[31:4], dsc[i][DESC_PREF], 2'h0, dsc[i][DESC_IO]});
		end
		// Second pass: multiplexed bus and a slow slave
		for (m = 0; m < 2; m++) begin
			mode <= 1'(m);
			dly <= 4'(2*m);
			for (i = 0; i < 4; i++) begin
				a = {16'h8000, 4'(i), 7'h0, 1'(m), 2'(i), 2'h0};
				x = $random(seed);
				y = $random(seed);
				// 8-bit gap write keeps lane 0 only; others take the top half
				e = (i == 2) ? 32'h0000_00ff : 32'hffff_0000;
				hx(i == 3 ? CMD_IO_WR : (m ? CMD_MEM_WR_INV : CMD_MEM_WR), a, 4'h0, x);
				hx(rc[i], a | 32'h3, 4'h0, x);
				hx(i == 3 ? CMD_IO_WR : CMD_MEM_WR, a, (i == 2) ? 4'ha : 4'h3, y);
				hx(rc[i], a, 4'h0, (y & e) | (x & ~e));
			end
		end
		end_of_test();
	end
endmodule
`default_nettype wire
